// file: bench/sgc_cfg_asserts.sv
// Checker for the global configuration bank and storm drop flag
`timescale 1ns/10ps
module sgc_cfg_asserts
(
  // Clock, reset and register port
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [7:0]                  reg_addr,
  input wire logic                        reg_wr,
  input wire logic [7:0]                  reg_wdata,
  // Watched outputs and frame events
  input wire logic                        vlan_en,
  input wire logic                        igmp_snoop_en,
  input wire logic                        mirror_match_both,
  input wire logic [sgc_pkg::SGC_THR_W-1:0] storm_threshold,
  input wire logic [4:0]                  frame_start,
  input wire logic [4:0]                  storm_drop
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Write cycles to each mapped offset
  sequence w5; reg_wr && reg_addr == 8'h05; endsequence
  sequence w6; reg_wr && reg_addr == 8'h06; endsequence
  sequence w7; reg_wr && reg_addr == 8'h07; endsequence
  vlan_bit_a: assert property (w5 |=> vlan_en == $past(reg_wdata[7])) else $error("vlan bit");
  snoop_bit_a: assert property (w5 |=> igmp_snoop_en == $past(reg_wdata[6])) else $error("snoop bit");
  mirror_bit_a: assert property (w5 |=> mirror_match_both == $past(reg_wdata[0])) else $error("mirror bit");
  thr_high_a: assert property (w6 |=> storm_threshold[10:8] == $past(reg_wdata[2:0])) else $error("thr hi");
  thr_low_a: assert property (w7 |=> storm_threshold[7:0] == $past(reg_wdata)) else $error("thr lo");
  thr_reset_a: assert property (disable iff (1'b0) rst |=> storm_threshold == 11'h04A) else $error("thr rst");
  drop_cause_a: assert property ($rose(storm_drop[0]) |-> $past(frame_start[0])) else $error("drop cause");
  drop_hold_a: assert property (!frame_start[0] |=> $stable(storm_drop[0])) else $error("drop hold");
endmodule // sgc_cfg_asserts
bind sgc_global_cfg sgc_cfg_asserts sgc_cfg_asserts_i (.*);

// file: bench/testbench.sv
// Self-checking bench for the global configuration bank
`timescale 1ns/10ps
module testbench;
  localparam int FAST = 200;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, mcast_storm_disable = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic vlan_en, igmp_snoop_en, mirror_match_both, null_vid_replace_en;
  logic uplink_port_mii_backpress_en, uplink_port_mii_half_duplex;
  logic uplink_port_mii_flow_ctrl_en, uplink_port_mii_speed10;
  logic [10:0] storm_threshold;
  logic [4:0] port_slow_rate = 0, frame_start = 0, frame_da_bcast = 0, frame_da_group = 0;
  logic [4:0] block_strobe = 0, storm_drop;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  wire [4:0] up = {uplink_port_mii_backpress_en, uplink_port_mii_half_duplex,
    uplink_port_mii_flow_ctrl_en, uplink_port_mii_speed10, null_vid_replace_en};
  sgc_global_cfg #(.FAST_CYCLES(FAST), .SLOW_CYCLES(10 * FAST)) sgc_global_cfg_i (.*);
  ////////////////////////////////////////
  // Clock and cycle count since reset
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1 reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(posedge clk) #1 reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) #1 reg_addr = a; reg_rd = 1;
    @(posedge clk) #1 reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  task automatic fr(input logic b, g, e);
    @(posedge clk) #1 frame_start = '1; frame_da_bcast = {5{b}}; frame_da_group = {5{g}};
    @(posedge clk) #1 frame_start = 0;
    chk(storm_drop, {5{e}});
  endtask
  task automatic blk(input int n);
    repeat (n)
    begin
      @(posedge clk) #1 block_strobe = '1;
      @(posedge clk) #1 block_strobe = 0;
    end
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk({vlan_en, igmp_snoop_en, mirror_match_both, up}, 0);
    chk(storm_threshold, 11'h04A);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h4A);
  endtask
  task automatic t_bits;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h05, 8'h01 << i);
      chk({vlan_en, igmp_snoop_en, mirror_match_both}, {i == 7, i == 6, i == 0});
      rd(8'h05, (8'h01 << i) & 8'hC1);
      wr(8'h06, 8'h01 << i);
      chk(up, (8'h01 << i) >> 3);
      rd(8'h06, 8'h01 << i);
    end
  endtask
  task automatic t_thr;
    wr(8'h06, 8'h05);
    wr(8'h07, 8'h3C);
    chk(storm_threshold, 11'h53C);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h07, 8'h3C);
  endtask
  task automatic align;
    while (cyc % FAST != 5) @(posedge clk);
  endtask
  task automatic t_storm;
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h02);
    align;
    fr(1, 0, 0);
    blk(1);
    fr(1, 0, 0);
    blk(1);
    fr(1, 0, 1);
    blk(3);
    fr(0, 1, 0);
    mcast_storm_disable = 0;
    fr(0, 1, 1);
    align;
    fr(1, 0, 0);
  endtask
  task automatic t_slow;
    align;
    #1 port_slow_rate = '1;
    fr(1, 0, 0);
    blk(2);
    fr(1, 0, 1);
    repeat (250) @(posedge clk);
    fr(1, 0, 1);
    repeat (1800) @(posedge clk);
    fr(1, 0, 0);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    t_reset;
    t_bits;
    t_thr;
    t_storm;
    t_slow;
    conclude;
  end
  initial
  begin
    #(10000 * 100);
    n_mismatch++;
    conclude;
  end
endmodule // testbench

// file: rtl/sgc_global_cfg.sv
// Global configuration registers and per-port broadcast storm limiter
`timescale 1ns/10ps
module sgc_global_cfg
  import sgc_pkg::*;
#(
  parameter int FAST_CYCLES = sgc_pkg::SGC_FAST_CYCLES,
  parameter int SLOW_CYCLES = sgc_pkg::SGC_SLOW_CYCLES
)
(
  // Clock and reset
  input  wire  logic                            clk,
  input  wire  logic                            rst,
  // Management register port
  input  wire  logic [7:0]                      reg_addr,
  input  wire  logic                            reg_wr,
  input  wire  logic [7:0]                      reg_wdata,
  input  wire  logic                            reg_rd,
  output logic [7:0]                            reg_rdata,
  // Configuration outputs
  output logic                                  vlan_en,
  output logic                                  igmp_snoop_en,
  output logic                                  mirror_match_both,
  output logic                                  uplink_port_mii_backpress_en,
  output logic                                  uplink_port_mii_half_duplex,
  output logic                                  uplink_port_mii_flow_ctrl_en,
  output logic                                  uplink_port_mii_speed10,
  output logic                                  null_vid_replace_en,
  output logic [sgc_pkg::SGC_THR_W-1:0]         storm_threshold,
  // Storm limiter port events
  input  wire  logic                            mcast_storm_disable,
  input  wire  logic [sgc_pkg::SGC_PORTS-1:0]   port_slow_rate,
  input  wire  logic [sgc_pkg::SGC_PORTS-1:0]   frame_start,
  input  wire  logic [sgc_pkg::SGC_PORTS-1:0]   frame_da_bcast,
  input  wire  logic [sgc_pkg::SGC_PORTS-1:0]   frame_da_group,
  input  wire  logic [sgc_pkg::SGC_PORTS-1:0]   block_strobe,
  output logic [sgc_pkg::SGC_PORTS-1:0]         storm_drop
);
  import sgc_pkg::*;

  localparam logic [SGC_TMR_W-1:0] FAST_LAST = SGC_TMR_W'(FAST_CYCLES - 1);
  localparam logic [SGC_TMR_W-1:0] SLOW_LAST = SGC_TMR_W'(SLOW_CYCLES - 1);
  localparam logic [SGC_THR_W-1:0] CNT_ONE   = 11'h001;
  localparam logic [SGC_TMR_W-1:0] TMR_ONE   = 23'h000001;

  logic [7:0] thr_low;
  logic       sel_vsm;
  logic       sel_ush;
  logic       sel_srl;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode, one select per mapped offset; unmapped offsets select nothing
  assign sel_vsm = reg_wr & (reg_addr == SGC_ADDR_VLAN_SNOOP_MIRROR);
  assign sel_ush = reg_wr & (reg_addr == SGC_ADDR_UPLINK_STORM_HIGH);
  assign sel_srl = reg_wr & (reg_addr == SGC_ADDR_STORM_RATE_LOW);

  //////////////////////////////////////////////////////////////////////////////
  // Tag-based VLAN enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vlan_en <= 1'b0;
    end
    else if (sel_vsm)
    begin
      vlan_en <= reg_wdata[SGC_BIT_VLAN_EN];
    end
  end

  // IGMP snoop toward the uplink
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      igmp_snoop_en <= 1'b0;
    end
    else if (sel_vsm)
    begin
      igmp_snoop_en <= reg_wdata[SGC_BIT_SNOOP_EN];
    end
  end

  // Mirror match select, reserved bits 5:1 are not stored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mirror_match_both <= 1'b0;
    end
    else if (sel_vsm)
    begin
      mirror_match_both <= reg_wdata[SGC_BIT_MIRROR];
    end
  end

  // Uplink back pressure enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uplink_port_mii_backpress_en <= 1'b0;
    end
    else if (sel_ush)
    begin
      uplink_port_mii_backpress_en <= reg_wdata[SGC_BIT_BACKPRESS];
    end
  end

  // Uplink duplex select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uplink_port_mii_half_duplex <= 1'b0;
    end
    else if (sel_ush)
    begin
      uplink_port_mii_half_duplex <= reg_wdata[SGC_BIT_HALF_DUP];
    end
  end

  // Uplink flow control enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uplink_port_mii_flow_ctrl_en <= 1'b0;
    end
    else if (sel_ush)
    begin
      uplink_port_mii_flow_ctrl_en <= reg_wdata[SGC_BIT_FLOW_CTRL];
    end
  end

  // Uplink speed select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uplink_port_mii_speed10 <= 1'b0;
    end
    else if (sel_ush)
    begin
      uplink_port_mii_speed10 <= reg_wdata[SGC_BIT_SPEED10];
    end
  end

  // Null VID replacement enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      null_vid_replace_en <= 1'b0;
    end
    else if (sel_ush)
    begin
      null_vid_replace_en <= reg_wdata[SGC_BIT_NULL_VID];
    end
  end

  // Threshold high bits, written independently of the low byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      storm_threshold[SGC_THR_W-1:8] <= SGC_RST_THR[SGC_THR_W-1:8];
    end
    else if (sel_ush)
    begin
      storm_threshold[SGC_THR_W-1:8] <= reg_wdata[SGC_THR_HI_MSB:0];
    end
  end

  // Threshold low byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      storm_threshold[7:0] <= SGC_RST_THR[7:0];
    end
    else if (sel_srl)
    begin
      storm_threshold[7:0] <= reg_wdata;
    end
  end

  assign thr_low = storm_threshold[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Register reads, reserved bits and unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= SGC_RST_BYTE;
    end
    else if (reg_rd)
    begin
      if (reg_addr == SGC_ADDR_VLAN_SNOOP_MIRROR)
      begin
        reg_rdata <= {vlan_en, igmp_snoop_en, 5'h00, mirror_match_both};
      end
      else if (reg_addr == SGC_ADDR_UPLINK_STORM_HIGH)
      begin
        reg_rdata <= {uplink_port_mii_backpress_en, uplink_port_mii_half_duplex,
                      uplink_port_mii_flow_ctrl_en, uplink_port_mii_speed10,
                      null_vid_replace_en, storm_threshold[SGC_THR_W-1:8]};
      end
      else if (reg_addr == SGC_ADDR_STORM_RATE_LOW)
      begin
        reg_rdata <= thr_low;
      end
      else
      begin
        reg_rdata <= SGC_RST_BYTE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-port storm limiter
  genvar p;
  generate
    for (p = 0; p < SGC_PORTS; p++)
    begin : g_port
      logic [SGC_TMR_W-1:0] tmr_r;
      logic [SGC_THR_W-1:0] cnt_r;
      logic                 reg_frame_r;
      logic                 period_end;
      logic                 regulated;
      logic                 limit_hit;

      // Period length follows the port rate
      assign period_end = port_slow_rate[p] ? (tmr_r >= SLOW_LAST) : (tmr_r >= FAST_LAST);
      // Group addresses count only when multicast inclusion is on
      assign regulated  = frame_da_bcast[p] | (frame_da_group[p] & ~mcast_storm_disable);
      assign limit_hit  = (cnt_r >= storm_threshold);

      // Period timer
      always_ff @(posedge clk)
      begin
        if (rst | period_end)
        begin
          tmr_r <= '0;
        end
        else
        begin
          tmr_r <= tmr_r + TMR_ONE;
        end
      end

      // Frame classification latched at frame start
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          reg_frame_r   <= 1'b0;
          storm_drop[p] <= 1'b0;
        end
        else if (frame_start[p])
        begin
          reg_frame_r   <= regulated;
          storm_drop[p] <= regulated & limit_hit & ~period_end;
        end
      end

      // Admitted 64-byte blocks, cleared at every period boundary
      always_ff @(posedge clk)
      begin
        if (rst | period_end)
        begin
          cnt_r <= '0;
        end
        else if (block_strobe[p] & reg_frame_r & ~storm_drop[p] & ~limit_hit)
        begin
          cnt_r <= cnt_r + CNT_ONE;
        end
      end
    end
  endgenerate

endmodule // sgc_global_cfg

// file: rtl/sgc_pkg.sv
// Package of offsets, field positions, reset values and timing for the global config bank
package sgc_pkg;
  // Register offsets on the management port
  localparam logic [7:0] SGC_ADDR_VLAN_SNOOP_MIRROR = 8'h05;
  localparam logic [7:0] SGC_ADDR_UPLINK_STORM_HIGH = 8'h06;
  localparam logic [7:0] SGC_ADDR_STORM_RATE_LOW    = 8'h07;

  // Field positions in vlan_snoop_mirror_ctrl
  localparam int SGC_BIT_VLAN_EN   = 7;
  localparam int SGC_BIT_SNOOP_EN  = 6;
  localparam int SGC_BIT_MIRROR    = 0;

  // Field positions in uplink_port_ctrl_storm_high
  localparam int SGC_BIT_BACKPRESS = 7;
  localparam int SGC_BIT_HALF_DUP  = 6;
  localparam int SGC_BIT_FLOW_CTRL = 5;
  localparam int SGC_BIT_SPEED10   = 4;
  localparam int SGC_BIT_NULL_VID  = 3;
  localparam int SGC_THR_HI_MSB    = 2;

  // Widths
  localparam int SGC_THR_W   = 11;
  localparam int SGC_PORTS   = 5;
  localparam int SGC_TMR_W   = 23;

  // Reset values
  localparam logic [7:0]           SGC_RST_BYTE = 8'h00;
  localparam logic [SGC_THR_W-1:0] SGC_RST_THR  = 11'h04A;

  // Measurement periods and clock rate
  localparam int SGC_PERIOD_FAST_MS = 50;
  localparam int SGC_PERIOD_SLOW_MS = 500;
  localparam int SGC_CLK_KHZ        = 10000;
  localparam int SGC_FAST_CYCLES    = SGC_PERIOD_FAST_MS * SGC_CLK_KHZ;
  localparam int SGC_SLOW_CYCLES    = SGC_PERIOD_SLOW_MS * SGC_CLK_KHZ;
endpackage
